// File: xpt_pkg.sv
// Shared constants for the crosspoint serial configuration link
package xpt_pkg;
    localparam int WORD_W       = 16;
    localparam int IDX_W        = 5;
    localparam int NUM_CH       = 32;
    localparam int BANK_W       = 8;
    localparam int CMD_HI       = 15;
    localparam int CMD_LO       = 13;
    localparam int SRC_HI       = 12;
    localparam int SRC_LO       = 8;
    localparam int DST_HI       = 4;
    localparam int DST_LO       = 0;
    localparam int BANK_HI      = 9;
    localparam int BANK_LO      = 8;
    localparam int DATA_HI      = 7;
    localparam int DATA_LO      = 0;
    localparam int BCAST_EN_BIT = 0;
    localparam int CLAMP_BIT    = 9;
    localparam int POWER_BIT    = 1;
    localparam int GLOBAL_BIT   = 0;
    localparam int MCLK_NS      = 10;
    localparam int SCLK_MIN_NS  = 200;
    // Half period of generated serial clock, rounded up to whole cycles
    localparam int SCLK_HALF_CYC = (SCLK_MIN_NS / 2 + MCLK_NS - 1) / MCLK_NS;

    typedef enum logic [2:0] {
        CMD_MAP   = 3'h0,
        CMD_OEN   = 3'h1,
        CMD_GAIN  = 3'h2,
        CMD_BCAST = 3'h3,
        CMD_CTRL  = 3'h7
    } cmd_t;
endpackage : xpt_pkg

// File: xpt_link_if.sv
// Three-wire serial configuration link plus daisy-chain output
`timescale 1ns/10ps
interface xpt_link_if;
    logic sclk;
    logic serial_in_line;
    logic word_commit_strobe;
    logic chain_out_line;

    modport dev (
        input  sclk,
        input  serial_in_line,
        input  word_commit_strobe,
        output chain_out_line
    );
    modport host (
        output sclk,
        output serial_in_line,
        output word_commit_strobe,
        input  chain_out_line
    );
endinterface : xpt_link_if

// File: xpt_host.sv
// Host end: shifts command words out LSB first and commits them
`timescale 1ns/10ps
module xpt_host #(
    parameter int CHAIN_LEN = 1
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    xpt_link_if.host                    link,
    input  wire logic                   req_valid,
    input  wire logic [xpt_pkg::WORD_W*CHAIN_LEN-1:0] req_data,
    output logic                        req_ready,
    output logic                        done_pulse
);
    import xpt_pkg::*;

    localparam int NBITS = WORD_W * CHAIN_LEN;
    localparam int CNT_W = $clog2(NBITS + 1);
    localparam int DIV_W = $clog2(SCLK_HALF_CYC + 1);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LOW   = 4'b0010,
        ST_HIGH  = 4'b0100,
        ST_LATCH = 4'b1000
    } hstate_t;

    hstate_t               state_r;
    logic [NBITS-1:0]      shreg_r;
    logic [CNT_W-1:0]      bits_r;
    logic [DIV_W-1:0]      div_r;
    logic                  sclk_r;
    logic                  sdi_r;
    logic                  strobe_r;
    logic                  ready_r;
    logic                  done_r;
    logic                  tick;

    assign tick = (div_r == DIV_W'(SCLK_HALF_CYC - 1));

    assign link.sclk               = sclk_r;
    assign link.serial_in_line     = sdi_r;
    assign link.word_commit_strobe = strobe_r;
    assign req_ready               = ready_r;
    assign done_pulse              = done_r;

    // ==========================================
    // Clock divider
    always_ff @(posedge mclk) begin
        if (!rst_b || state_r == ST_IDLE || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DIV_W'(1);
        end
    end

    // ==========================================
    // Shift sequencer: data changes while sclk is low, device samples on rise
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r  <= ST_IDLE;
            shreg_r  <= '0;
            bits_r   <= '0;
            sclk_r   <= 1'b0;
            sdi_r    <= 1'b0;
            strobe_r <= 1'b0;
            ready_r  <= 1'b0;
            done_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    ready_r <= 1'b1;
                    if (req_valid && ready_r) begin
                        ready_r  <= 1'b0;
                        strobe_r <= 1'b0;
                        sdi_r   <= req_data[0];
                        shreg_r <= req_data >> 1;
                        bits_r  <= CNT_W'(NBITS);
                        state_r <= ST_LOW;
                    end
                end
                ST_LOW: if (tick) begin
                    sclk_r  <= 1'b1;
                    bits_r  <= bits_r - CNT_W'(1);
                    state_r <= ST_HIGH;
                end
                ST_HIGH: if (tick) begin
                    sclk_r <= 1'b0;
                    if (bits_r == '0) begin
                        state_r <= ST_LATCH;
                    end else begin
                        sdi_r   <= shreg_r[0];
                        shreg_r <= shreg_r >> 1;
                        state_r <= ST_LOW;
                    end
                end
                // Strobe stays up until the next word, so a slow sampler cannot miss it
                ST_LATCH: if (tick) begin
                    strobe_r <= 1'b1;
                    done_r   <= 1'b1;
                    state_r  <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : xpt_host

// File: xpt_device.sv
// Device end: serial shift register, command decoder and crosspoint state
// Operation
// - Shift data in on serial clock rise
// - Shifting ignores commit strobe level
// - Bit 0 first, bit 15 last
// - Strobe rising edge commits shifted word
// - Chain output is input delayed 15.5 clocks
// - No readback; chain output only delays
// - Host shifts 16 bits per device, one strobe
// - Bits 15..13 select command
// - Map word: source 12..8, destination 4..0
// - Each output keeps its own source
// - Host sends 32 map words to fill
// - Enable word: bank 9..8, eight bits
// - Output on needs own and global enable
// - Gain word banked like enable word
// - Gain bit 0 unity, 1 double
// - Power-up disables every output
// - Broadcast: source, enable bit, restores map
// - Control: clamp, operational, global enable
// - Reset enters standby until control word
`timescale 1ns/10ps
module xpt_device #(
    parameter int NCH = xpt_pkg::NUM_CH
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_b,
    xpt_link_if.dev                         link,
    output logic [NCH-1:0][xpt_pkg::IDX_W-1:0] route_src,
    output logic [NCH-1:0]                  out_drive,
    output logic [NCH-1:0]                  gain_double,
    output logic                            clamp_on,
    output logic                            operational,
    output logic                            commit_pulse
);
    import xpt_pkg::*;

    logic [2:0]              sclk_sy_r;
    logic [1:0]              sdi_sy_r;
    logic [2:0]              lat_sy_r;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    lat_rise;
    logic [WORD_W-1:0]       shreg_r;
    logic                    chain_r;
    logic [IDX_W-1:0]        map_r [NCH];
    logic [NCH-1:0]          oen_r;
    logic [NCH-1:0]          gain_r;
    logic [IDX_W-1:0]        bsrc_r;
    logic                    bcast_r;
    logic                    clamp_r;
    logic                    oper_r;
    logic                    global_r;
    logic [NCH-1:0][IDX_W-1:0] route_r;
    logic [NCH-1:0]          drive_r;
    logic                    commit_r;
    cmd_t                    cmd;
    logic [1:0]              bank;
    logic [BANK_W-1:0]       bdata;

    // ==========================================
    // Synchronisers; first stage feeds only second
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sclk_sy_r <= '0;
            sdi_sy_r  <= '0;
            lat_sy_r  <= '0;
        end else begin
            sclk_sy_r <= {sclk_sy_r[1:0], link.sclk};
            sdi_sy_r  <= {sdi_sy_r[0], link.serial_in_line};
            lat_sy_r  <= {lat_sy_r[1:0], link.word_commit_strobe};
        end
    end

    assign sclk_rise = sclk_sy_r[1] && !sclk_sy_r[2];
    assign sclk_fall = !sclk_sy_r[1] && sclk_sy_r[2];
    assign lat_rise  = lat_sy_r[1] && !lat_sy_r[2];

    // ==========================================
    // Shift register, strobe level not consulted
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            shreg_r <= '0;
        end else if (sclk_rise) begin
            shreg_r <= {sdi_sy_r[1], shreg_r[WORD_W-1:1]};
        end
    end

    // Oldest bit sits at shreg_r[0]; it left on the rise 15 clocks ago,
    // so driving it on the next fall gives the 15.5 clock delay.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            chain_r <= 1'b0;
        end else if (sclk_fall) begin
            chain_r <= shreg_r[0];
        end
    end
    assign link.chain_out_line = chain_r;

    // ==========================================
    // Command decode
    assign cmd   = cmd_t'(shreg_r[CMD_HI:CMD_LO]);
    assign bank  = shreg_r[BANK_HI:BANK_LO];
    assign bdata = shreg_r[DATA_HI:DATA_LO];

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < NCH; i++) begin
                map_r[i] <= '0;
            end
        end else if (lat_rise && cmd == CMD_MAP) begin
            map_r[shreg_r[DST_HI:DST_LO]] <= shreg_r[SRC_HI:SRC_LO];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            oen_r  <= '0;
            gain_r <= '0;
        end else if (lat_rise) begin
            if (cmd == CMD_OEN) begin
                oen_r[bank*BANK_W +: BANK_W] <= bdata;
            end
            if (cmd == CMD_GAIN) begin
                gain_r[bank*BANK_W +: BANK_W] <= bdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bsrc_r   <= '0;
            bcast_r  <= 1'b0;
            clamp_r  <= 1'b0;
            oper_r   <= 1'b0;
            global_r <= 1'b0;
        end else if (lat_rise) begin
            // Codes 100, 101 and 110 fall through with no effect
            if (cmd == CMD_BCAST) begin
                bsrc_r  <= shreg_r[SRC_HI:SRC_LO];
                bcast_r <= shreg_r[BCAST_EN_BIT];
            end
            if (cmd == CMD_CTRL) begin
                clamp_r  <= shreg_r[CLAMP_BIT];
                oper_r   <= shreg_r[POWER_BIT];
                global_r <= shreg_r[GLOBAL_BIT];
            end
        end
    end

    // ==========================================
    // Registered outputs; map kept intact so broadcast off restores it
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_out
            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    route_r[g] <= '0;
                    drive_r[g] <= 1'b0;
                end else begin
                    route_r[g] <= bcast_r ? bsrc_r : map_r[g];
                    drive_r[g] <= oen_r[g] && global_r;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            commit_r <= 1'b0;
        end else begin
            commit_r <= lat_rise;
        end
    end

    assign route_src    = route_r;
    assign out_drive    = drive_r;
    assign gain_double  = gain_r;
    assign clamp_on     = clamp_r;
    assign operational  = oper_r;
    assign commit_pulse = commit_r;
endmodule : xpt_device

// File: xpt_link_chk.sv
// Assertions on the serial configuration link wires
`timescale 1ns/10ps
module xpt_link_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic serial_in_line,
    input wire logic word_commit_strobe,
    input wire logic chain_out_line
);
    logic [15:0] sh_r;
    logic [5:0]  cnt_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ====================================
    // Reference copy of bits seen on the wire
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sh_r <= 16'h0000;
        end else if ($rose(sclk)) begin
            sh_r <= {sh_r[14:0], serial_in_line};
        end
    end
    // Rises since the last commit; a chain of one needs exactly one word
    always_ff @(posedge mclk) begin
        if (!rst_b || $rose(word_commit_strobe)) begin
            cnt_r <= 6'h00;
        end else if ($rose(sclk)) begin
            cnt_r <= cnt_r + 6'h01;
        end
    end
    // ====================================
    // Properties
    chk_data_still: assert property (sclk |-> $stable(serial_in_line))
        else $error("data moved while clock high");
    chk_high_time: assert property ($rose(sclk) |-> sclk [*8])
        else $error("clock high phase too short");
    chk_low_time: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("clock low phase too short");
    chk_strobe_quiet: assert property (word_commit_strobe |-> !sclk)
        else $error("clock ran during commit");
    chk_word_bits: assert property ($rose(word_commit_strobe) |-> cnt_r == 6'h10)
        else $error("commit not after sixteen bits");
    chk_commit_due:
        assert property ($fell(sclk) && cnt_r == 6'h10 |-> ##[8:12] $rose(word_commit_strobe))
        else $error("commit missing after word");
    chk_chain_edge: assert property ($changed(chain_out_line) |-> !sclk && !$past(sclk, 2))
        else $error("chain output moved off falling edge");
    chk_chain_delay: assert property ($rose(sclk) |-> chain_out_line == sh_r[15])
        else $error("chain output not the delayed input");
    cover property ($rose(word_commit_strobe));
    cover property ($changed(chain_out_line));
    cover property ($rose(sclk) && serial_in_line);
endmodule : xpt_link_chk

// File: crosspoint_serial_config_decoder_test.sv
// Self-checking bench: host and device ends joined by the link
`timescale 1ns/10ps
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module crosspoint_serial_config_decoder_test;
    import xpt_pkg::*;
    logic                mclk;
    logic                rst_b;
    logic                req_valid;
    logic [15:0]         req_data;
    logic                req_ready;
    logic                done_pulse;
    logic [31:0][4:0]    route_src;
    logic [31:0]         out_drive;
    logic [31:0]         gain_double;
    logic                clamp_on;
    logic                operational;
    logic                commit_pulse;
    int                  error_cnt;
    int                  checks;
    int                  seed;
    logic [15:0]         w;
    logic [4:0]          map_m [32];
    logic [31:0]         en_m;
    logic [31:0]         gain_m;
    logic [4:0]          bsrc_m;
    logic                ben_m;
    logic                clamp_m;
    logic                oper_m;
    logic                glob_m;
    xpt_link_if link ();
    xpt_host #(.CHAIN_LEN(1)) i_xpt_host (.mclk(mclk), .rst_b(rst_b), .link(link),
        .req_valid(req_valid), .req_data(req_data), .req_ready(req_ready),
        .done_pulse(done_pulse));
    xpt_device #(.NCH(32)) i_xpt_device (.mclk(mclk), .rst_b(rst_b), .link(link),
        .route_src(route_src), .out_drive(out_drive), .gain_double(gain_double),
        .clamp_on(clamp_on), .operational(operational), .commit_pulse(commit_pulse));
    xpt_link_chk i_xpt_link_chk (.mclk(mclk), .rst_b(rst_b), .sclk(link.sclk),
        .serial_in_line(link.serial_in_line), .word_commit_strobe(link.word_commit_strobe),
        .chain_out_line(link.chain_out_line));
    always #5 mclk = ~mclk;
    // ====================================
    // Tasks
    task tally_and_finish;
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // Holds the request until the host has taken it, then expects one commit
    task send(input logic [15:0] v);
        int n;
        int p;
        @(negedge mclk);
        while (req_ready !== 1'b1) @(negedge mclk);
        req_valid = 1'b1;
        req_data = v;
        @(negedge mclk);
        req_valid = 1'b0;
        n = 0;
        p = 0;
        while (done_pulse !== 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        repeat (12) begin
            @(negedge mclk);
            p += (commit_pulse === 1'b1);
        end
        `CMP(n < 1000, 1'b1)
        `CMP(p, 1)
    endtask : send
    task check_all;
        logic [31:0][4:0] er;
        for (int k = 0; k < 32; k++) er[k] = ben_m ? bsrc_m : map_m[k];
        `CMP(route_src, er)
        `CMP(out_drive, en_m & {32{glob_m}})
        `CMP(gain_double, gain_m)
        `CMP({clamp_on, operational}, {clamp_m, oper_m})
    endtask : check_all
    // ====================================
    // Main sequence
    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_data = 16'h0000;
        seed = 32'hda0c_92de;
        error_cnt = 0;
        checks = 0;
        {en_m, gain_m, bsrc_m, ben_m, clamp_m, oper_m, glob_m} = '0;
        foreach (map_m[k]) map_m[k] = 5'h00;
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        repeat (2) @(negedge mclk);
        `CMP(out_drive, 32'h0000_0000)
        `CMP(operational, 1'b0)
        // Fill the whole map, one word and one commit per output
        for (int k = 0; k < 32; k++) begin
            w = 16'($random(seed));
            w[15:13] = 3'h0;
            w[4:0] = k[4:0];
            send(w);
            map_m[k] = w[12:8];
        end
        for (int k = 0; k < 32; k++) `CMP(route_src[k], map_m[k])
        check_all();
        // Every command code first, then a random mix with junk in ignored bits
        for (int i = 0; i < 200; i++) begin
            w = 16'($random(seed));
            if (i < 8) w[15:13] = i[2:0];
            send(w);
            case (w[15:13])
                3'h0: map_m[w[4:0]] = w[12:8];
                3'h1: en_m[w[9:8]*8 +: 8] = w[7:0];
                3'h2: gain_m[w[9:8]*8 +: 8] = w[7:0];
                3'h3: {bsrc_m, ben_m} = {w[12:8], w[0]};
                3'h7: {clamp_m, oper_m, glob_m} = {w[9], w[1], w[0]};
                default: ;
            endcase
            check_all();
        end
        // Drive a bank with the global enable on, then reset mid-run
        send(16'h21ff);
        en_m[15:8] = 8'hff;
        send(16'he003);
        {clamp_m, oper_m, glob_m} = 3'b011;
        check_all();
        rst_b = 1'b0;
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        {en_m, gain_m, bsrc_m, ben_m, clamp_m, oper_m, glob_m} = '0;
        foreach (map_m[k]) map_m[k] = 5'h00;
        repeat (2) @(negedge mclk);
        `CMP(out_drive, 32'h0000_0000)
        `CMP(operational, 1'b0)
        check_all();
        tally_and_finish();
    end
    initial begin
        // About 81k cycles of work are expected; stay under 95k in all
        #950_000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : crosspoint_serial_config_decoder_test
